/* File: hw/simlc_map.vh */
// constants of the switch interrupt mask and sleep timing block
// assumes: included by the design file by its bare name
`ifndef SIMLC_MAP_VH
`define SIMLC_MAP_VH

// ----------------------------------------------------------------
// register address codes, bits 31 to 25 of a frame
// ----------------------------------------------------------------
`define SIMLC_ADDR_PROG_IRQ_EN   7'h0d
`define SIMLC_ADDR_GND_IRQ_EN    7'h0e
`define SIMLC_ADDR_SLEEP_CFG     7'h0f

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SIMLC_FRAME_BITS         6'h20
`define SIMLC_ADDR_MSB           31
`define SIMLC_ADDR_LSB           25
`define SIMLC_RW_BIT             24
`define SIMLC_REPLY_FAULT_BIT    23
`define SIMLC_REPLY_IRQ_BIT      22

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SIMLC_PROG_EN_MSB        7
`define SIMLC_GND_EN_MSB         13
`define SIMLC_WAKE_MSB           7
`define SIMLC_WAKE_LSB           4
`define SIMLC_POLL_MSB           3
`define SIMLC_POLL_LSB           0
`define SIMLC_PROG_EN_RESET      8'hff
`define SIMLC_GND_EN_RESET       14'h3fff
`define SIMLC_WAKE_RESET         4'h0
`define SIMLC_POLL_RESET         4'hf
`define SIMLC_WAKE_OFF           4'h0

// ----------------------------------------------------------------
// timing: clock period and timer tick, both in ns
// ----------------------------------------------------------------
`define SIMLC_CLK_PERIOD_NS      5
`define SIMLC_TICK_NS            1000000
`define SIMLC_TICK_CYC           (`SIMLC_TICK_NS / `SIMLC_CLK_PERIOD_NS)
`define SIMLC_GND_WIN_CYC        64   // ground poll window, clock cycles
`define SIMLC_BAT_WIN_CYC        128  // battery poll window, clock cycles

`endif

/* File: hw/simlc_core.v */
// interrupt enables, sleep wake timer and poll timer behind the serial port
// assumes: serial pins and switch levels arrive asynchronous to clk,
// fault summary and sleep request come from logic on clk
//
// What this block does
// - one enable bit per switch input
// - disabled input never raises an interrupt
// - enabled input change raises an interrupt
// - enable registers writable at any time
// - all enable bits reset to one
// - programmable enables at 0001_101, reply flags
// - ground enables at 0001_110, fourteen bits
// - sleep config at 0001_111, wake/poll fields
// - wake timer expiry leaves sleep, interrupts
// - wake code zero turns timer off
// - wake codes map to listed milliseconds
// - poll code sets time between polls
// - poll event opens ground and battery windows
// - poll codes map to listed milliseconds
`timescale 1ns/100ps
`default_nettype none
`include "simlc_map.vh"

module simlc_core #(
  parameter         TICK_CYC    = `SIMLC_TICK_CYC,
  parameter         GND_WIN_CYC = `SIMLC_GND_WIN_CYC,
  parameter         BAT_WIN_CYC = `SIMLC_BAT_WIN_CYC,
  parameter         PROG_INPUTS = 8,
  parameter         GND_INPUTS  = 14
) (
  input  wire                              clk,
  input  wire                              rst_n,
  input  wire                              spiSclk,
  input  wire                              spiCsN,
  input  wire                              spiMosi,
  output wire                              spiMiso,
  output wire                              spiMisoOe,
  input  wire [PROG_INPUTS+GND_INPUTS-1:0] switchLevel,
  input  wire                              faultSummary,
  input  wire                              sleepRequest,
  output wire                              sleepState,
  output wire                              irqN,
  output wire                              pollGroundActive,
  output wire                              pollBatteryActive
);

  localparam NIN = PROG_INPUTS + GND_INPUTS;

  // ----------------------------------------------------------------
  // millisecond tables
  // ----------------------------------------------------------------

  // wake timer code to ms, zero means off
  function [9:0] wakeMs;
    input [3:0] code;
    begin
      case (code)
        4'h1:    wakeMs = 10'h006;
        4'h2:    wakeMs = 10'h00c;
        4'h3:    wakeMs = 10'h018;
        4'h4:    wakeMs = 10'h030;
        4'h5:    wakeMs = 10'h060;
        4'h6:    wakeMs = 10'h0c0;
        4'h7:    wakeMs = 10'h18a;
        4'h8:    wakeMs = 10'h004;
        4'h9:    wakeMs = 10'h008;
        4'ha:    wakeMs = 10'h010;
        4'hb:    wakeMs = 10'h020;
        4'hc:    wakeMs = 10'h040;
        4'hd:    wakeMs = 10'h080;
        4'he:    wakeMs = 10'h100;
        4'hf:    wakeMs = 10'h200;
        default: wakeMs = 10'h000;
      endcase
    end
  endfunction

  // poll interval code to ms, 3 ms is the shortest
  function [9:0] pollMs;
    input [3:0] code;
    begin
      case (code)
        4'h0:    pollMs = 10'h003;
        4'h1:    pollMs = 10'h006;
        4'h2:    pollMs = 10'h00c;
        4'h3:    pollMs = 10'h018;
        4'h4:    pollMs = 10'h030;
        4'h5:    pollMs = 10'h044;
        4'h6:    pollMs = 10'h04c;
        4'h7:    pollMs = 10'h080;
        4'h8:    pollMs = 10'h020;
        4'h9:    pollMs = 10'h024;
        4'ha:    pollMs = 10'h028;
        4'hb:    pollMs = 10'h02c;
        4'hc:    pollMs = 10'h034;
        4'hd:    pollMs = 10'h038;
        4'he:    pollMs = 10'h03c;
        default: pollMs = 10'h040;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [2:0]     sclkSync_reg;
  reg [2:0]     csSync_reg;
  reg [1:0]     mosiSync_reg;
  reg [NIN-1:0] swMeta_reg;
  reg [NIN-1:0] swSync_reg;

  // two flops per pin, third sclk/cs flop only for edges
  always @(posedge clk) begin
    if (!rst_n) begin
      sclkSync_reg <= 3'h0;
      csSync_reg   <= 3'h7;
      mosiSync_reg <= 2'h0;
      swMeta_reg   <= {NIN{1'b0}};
      swSync_reg   <= {NIN{1'b0}};
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], spiSclk};
      csSync_reg   <= {csSync_reg[1:0], spiCsN};
      mosiSync_reg <= {mosiSync_reg[0], spiMosi};
      swMeta_reg   <= switchLevel;
      swSync_reg   <= swMeta_reg;
    end
  end

  wire sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2];
  wire sclkFall = ~sclkSync_reg[1] & sclkSync_reg[2];
  wire csFall   = ~csSync_reg[1] & csSync_reg[2];
  wire csRise   = csSync_reg[1] & ~csSync_reg[2];
  wire csActive = ~csSync_reg[1];

  // ----------------------------------------------------------------
  // registers and frame engine
  // ----------------------------------------------------------------
  reg [PROG_INPUTS-1:0] progIrqEn_reg;
  reg [GND_INPUTS-1:0]  gndIrqEn_reg;
  reg [3:0]             wakeSel_reg;
  reg [3:0]             pollSel_reg;
  reg [31:0]            rxShift_reg;
  reg [31:0]            txShift_reg;
  reg [5:0]             bitCnt_reg;
  reg [6:0]             replyAddr_reg;
  reg [21:0]            readData;

  wire [6:0]  frameAddr = rxShift_reg[`SIMLC_ADDR_MSB:`SIMLC_ADDR_LSB];
  wire        frameWr   = rxShift_reg[`SIMLC_RW_BIT];
  wire        frameOk   = csRise & (bitCnt_reg == `SIMLC_FRAME_BITS);
  wire        irqFlag;

  // readback of the register named in the previous frame
  always @* begin
    readData = 22'h000000;
    case (replyAddr_reg)
      `SIMLC_ADDR_PROG_IRQ_EN: readData[PROG_INPUTS-1:0] = progIrqEn_reg;
      `SIMLC_ADDR_GND_IRQ_EN:  readData[GND_INPUTS-1:0]  = gndIrqEn_reg;
      `SIMLC_ADDR_SLEEP_CFG:   readData[7:0] = {wakeSel_reg, pollSel_reg};
      default:                 readData = 22'h000000;
    endcase
  end

  // shift in on sclk rise, out on sclk fall, commit on cs rise
  always @(posedge clk) begin
    if (!rst_n) begin
      progIrqEn_reg <= `SIMLC_PROG_EN_RESET;
      gndIrqEn_reg  <= `SIMLC_GND_EN_RESET;
      wakeSel_reg   <= `SIMLC_WAKE_RESET;
      pollSel_reg   <= `SIMLC_POLL_RESET;
      rxShift_reg   <= 32'h00000000;
      txShift_reg   <= 32'h00000000;
      bitCnt_reg    <= 6'h00;
      replyAddr_reg <= 7'h00;
    end else begin
      if (csFall) begin
        bitCnt_reg  <= 6'h00;
        txShift_reg <= {faultSummary, irqFlag, readData, 8'h00};
      end else if (csActive && sclkRise) begin
        rxShift_reg <= {rxShift_reg[30:0], mosiSync_reg[1]};
        if (bitCnt_reg != 6'h3f)
          bitCnt_reg <= bitCnt_reg + 6'h01;
      end else if (csActive && sclkFall) begin
        txShift_reg <= {txShift_reg[30:0], 1'b0};
      end
      // a frame of any other length is dropped
      if (frameOk) begin
        replyAddr_reg <= frameAddr;
        if (frameWr) begin
          case (frameAddr)
            `SIMLC_ADDR_PROG_IRQ_EN: progIrqEn_reg <= rxShift_reg[`SIMLC_PROG_EN_MSB:0];
            `SIMLC_ADDR_GND_IRQ_EN:  gndIrqEn_reg  <= rxShift_reg[`SIMLC_GND_EN_MSB:0];
            `SIMLC_ADDR_SLEEP_CFG: begin
              wakeSel_reg <= rxShift_reg[`SIMLC_WAKE_MSB:`SIMLC_WAKE_LSB];
              pollSel_reg <= rxShift_reg[`SIMLC_POLL_MSB:`SIMLC_POLL_LSB];
            end
            default: ;
          endcase
        end
      end
    end
  end

  assign spiMiso   = txShift_reg[31];
  assign spiMisoOe = csActive;

  // ----------------------------------------------------------------
  // millisecond tick, sleep state, wake and poll timers
  // ----------------------------------------------------------------
  localparam ST_NORMAL = 1'b0;
  localparam ST_SLEEP  = 1'b1;

  reg        state_reg;
  reg [31:0] tickCnt_reg;
  reg [9:0]  wakeCnt_reg;
  reg [9:0]  pollCnt_reg;
  reg [31:0] gndWin_reg;
  reg [31:0] batWin_reg;
  reg        wakeFire;
  reg        pollEnd;

  wire msTick = (tickCnt_reg == TICK_CYC - 1);

  // divider for a one-cycle pulse each millisecond of sleep, held at zero in normal mode
  always @(posedge clk) begin
    if (!rst_n || state_reg == ST_NORMAL)
      tickCnt_reg <= 32'h00000000;
    else if (msTick)
      tickCnt_reg <= 32'h00000000;
    else
      tickCnt_reg <= tickCnt_reg + 32'h00000001;
  end

  // timer expiry and end of an active ground poll window
  always @* begin
    wakeFire = (state_reg == ST_SLEEP) && msTick && (wakeSel_reg != `SIMLC_WAKE_OFF) &&
               (wakeCnt_reg + 10'h001 >= wakeMs(wakeSel_reg));
    pollEnd  = (gndWin_reg == 32'h00000001);
  end

  // sleep entry on request, exit on wake timer
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_NORMAL;
    end else begin
      case (state_reg)
        ST_NORMAL: if (sleepRequest) state_reg <= ST_SLEEP;
        ST_SLEEP:  if (wakeFire) state_reg <= ST_NORMAL;
        default:   state_reg <= ST_NORMAL;
      endcase
    end
  end

  // ms counters; no poll window opens on the waking tick
  always @(posedge clk) begin
    if (!rst_n || state_reg == ST_NORMAL) begin
      wakeCnt_reg <= 10'h000;
      pollCnt_reg <= 10'h000;
      gndWin_reg  <= 32'h00000000;
      batWin_reg  <= 32'h00000000;
    end else begin
      if (msTick)
        wakeCnt_reg <= wakeFire ? 10'h000 : wakeCnt_reg + 10'h001;
      if (msTick && !wakeFire && pollCnt_reg + 10'h001 >= pollMs(pollSel_reg)) begin
        pollCnt_reg <= 10'h000;
        gndWin_reg  <= GND_WIN_CYC;
        batWin_reg  <= BAT_WIN_CYC;
      end else begin
        if (msTick)
          pollCnt_reg <= pollCnt_reg + 10'h001;
        if (gndWin_reg != 32'h00000000)
          gndWin_reg <= gndWin_reg - 32'h00000001;
        if (batWin_reg != 32'h00000000)
          batWin_reg <= batWin_reg - 32'h00000001;
      end
    end
  end

  assign sleepState        = state_reg;
  assign pollGroundActive  = (gndWin_reg != 32'h00000000);
  assign pollBatteryActive = (batWin_reg != 32'h00000000);

  // ----------------------------------------------------------------
  // change of state detection and pending interrupt flag
  // ----------------------------------------------------------------
  reg [NIN-1:0] reported_reg;
  reg           seeded_reg;
  reg           irqFlag_reg;

  // compare only in normal mode or at the end of a ground poll window
  wire          sampleNow = seeded_reg & ((state_reg == ST_NORMAL) | pollEnd);
  wire [NIN-1:0] changed  = swSync_reg ^ reported_reg;
  wire [NIN-1:0] enables  = {gndIrqEn_reg, progIrqEn_reg};
  wire          hit       = sampleNow & (|(changed & enables));

  // reported levels follow the sample, first sample seeds them
  always @(posedge clk) begin
    if (!rst_n) begin
      reported_reg <= {NIN{1'b0}};
      seeded_reg   <= 1'b0;
    end else if (!seeded_reg || sampleNow) begin
      reported_reg <= swSync_reg;
      seeded_reg   <= 1'b1;
    end
  end

  // set wins over the clear done by a completed frame
  always @(posedge clk) begin
    if (!rst_n)
      irqFlag_reg <= 1'b0;
    else if (hit || wakeFire)
      irqFlag_reg <= 1'b1;
    else if (frameOk)
      irqFlag_reg <= 1'b0;
  end

  assign irqFlag = irqFlag_reg;
  assign irqN    = ~irqFlag_reg;

endmodule

`default_nettype wire

/* File: verification/simlc_checker.sv */
// port checker of the switch interrupt mask and sleep timing block
// assumes: one clock, sync active-low reset, bound to simlc_core
`timescale 1ns/100ps
`default_nettype none
// ----
// checker
// ----
module simlc_checker #(
  parameter GND_WIN_CYC = 64,
  parameter BAT_WIN_CYC = 128
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spiCsN,
  input wire logic spiMisoOe,
  input wire logic sleepRequest,
  input wire logic sleepState,
  input wire logic irqN,
  input wire logic pollGroundActive,
  input wire logic pollBatteryActive
);
  logic [15:0] gndRun;
  logic [15:0] batRun;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // length of the open poll windows
  always @(posedge clk) begin
    gndRun <= (!rst_n || !pollGroundActive) ? 16'h0000 : gndRun + 16'h0001;
    batRun <= (!rst_n || !pollBatteryActive) ? 16'h0000 : batRun + 16'h0001;
  end
  a_oe_idle: assert property (spiCsN [*4] |-> !spiMisoOe) else $error("miso on while idle");
  a_oe_frame: assert property ((!spiCsN) [*4] |-> spiMisoOe) else $error("miso off in frame");
  a_poll_pair: assert property ($rose(pollGroundActive) |-> $rose(pollBatteryActive))
    else $error("windows not opened together");
  a_gnd_window: assert property ($fell(pollGroundActive) |-> gndRun == GND_WIN_CYC)
    else $error("ground window length");
  a_bat_window: assert property ($fell(pollBatteryActive) |-> batRun == BAT_WIN_CYC)
    else $error("battery window length");
  a_poll_sleep: assert property ($rose(pollGroundActive) |-> sleepState) else $error("poll when awake");
  a_sleep_enter: assert property (!sleepState && sleepRequest |=> sleepState) else $error("no sleep");
  a_sleep_cause: assert property ($rose(sleepState) |-> $past(sleepRequest)) else $error("sleep uncaused");
  a_wake_irq: assert property ($fell(sleepState) |-> !irqN) else $error("wake without interrupt");
  a_irq_hold: assert property (spiCsN [*6] ##0 !irqN |=> !irqN) else $error("flag lost");
endmodule
bind simlc_core simlc_checker #(.GND_WIN_CYC(GND_WIN_CYC), .BAT_WIN_CYC(BAT_WIN_CYC)) chk_u (
  .clk(clk), .rst_n(rst_n), .spiCsN(spiCsN), .spiMisoOe(spiMisoOe), .sleepRequest(sleepRequest),
  .sleepState(sleepState), .irqN(irqN), .pollGroundActive(pollGroundActive),
  .pollBatteryActive(pollBatteryActive));
`default_nettype wire

/* File: verification/simlc_host.sv */
// host controller model on the serial port
// assumes: ten system clocks per serial bit, changes at falling clk
`timescale 1ns/100ps
`default_nettype none
// ----
// serial master
// ----
module simlc_host (
  input  wire logic clk,
  output var  logic sclk,
  output var  logic csN,
  output var  logic mosi,
  input  wire logic miso,
  input  wire logic misoOe
);
  // idle levels
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
  end
  // one frame, msb first, reply taken at serial clock rise
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    integer i;
    begin
      @(negedge clk);
      csN = 1'b0;
      repeat (6) @(negedge clk);
      for (i = 31; i >= 0; i--) begin
        mosi = tx[i];
        repeat (5) @(negedge clk);
        sclk = 1'b1;
        rx[i] = misoOe ? miso : 1'bx;
        repeat (5) @(negedge clk);
        sclk = 1'b0;
      end
      repeat (5) @(negedge clk);
      csN  = 1'b1;
      mosi = ~mosi; // idle line does not keep the last bit
      repeat (8) @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_switch_irq_mask_lowpower_cfg.sv */
// self-checking bench of the switch interrupt mask and sleep timing block
// assumes: host model on the serial port, tick shortened to ten clocks
`timescale 1ns/100ps
`default_nettype none
// ----
// bench top
// ----
module tb_switch_irq_mask_lowpower_cfg;
  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        csN;
  logic        mosi;
  logic        miso;
  logic        misoOe;
  logic [21:0] switchLevel;
  logic        faultSummary;
  logic        sleepRequest;
  logic        sleepState;
  logic        irqN;
  logic        gndAct;
  logic        batAct;
  logic [31:0] rep;
  logic        seenPoll;
  integer      errors;
  integer      tests_run;
  integer      cyc;
  integer      n;
  simlc_core #(.TICK_CYC(10), .GND_WIN_CYC(4), .BAT_WIN_CYC(8)) dut_u (
    .clk(clk), .rst_n(rst_n), .spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi), .spiMiso(miso),
    .spiMisoOe(misoOe), .switchLevel(switchLevel), .faultSummary(faultSummary), .sleepRequest(sleepRequest),
    .sleepState(sleepState), .irqN(irqN), .pollGroundActive(gndAct), .pollBatteryActive(batAct));
  simlc_host host_u (.clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe));
  // clock and run limit
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // reply data belongs to the previous frame's address
  task automatic op(input logic [6:0] a, input logic w, input logic [23:0] d, input logic [21:0] prev);
    host_u.xfer({a, w, d}, rep);
    check(rep[29:8], prev);
  endtask
  task automatic nap;
    sleepRequest = 1'b1;
    @(negedge clk);
    sleepRequest = 1'b0;
    @(negedge clk);
  endtask
  task automatic sleepRun;
    n = 0;
    seenPoll = 1'b0;
    while (sleepState === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
      if (gndAct === 1'b1 && batAct === 1'b1) seenPoll = 1'b1;
    end
  endtask
  task automatic results;
    $display("tests=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    cyc = 0;
    rst_n = 1'b0;
    switchLevel = 22'h000000;
    faultSummary = 1'b0;
    sleepRequest = 1'b0;
    repeat (10) @(negedge clk);
    check({irqN, sleepState, misoOe}, 32'h4);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    op(7'h0d, 1'b0, 24'h0, 22'h0);
    op(7'h0e, 1'b0, 24'h0, 22'hff);
    op(7'h0f, 1'b0, 24'h0, 22'h3fff);
    faultSummary = 1'b1;
    op(7'h00, 1'b0, 24'h0, 22'h0f);
    check(rep[31], 1);
    faultSummary = 1'b0;
    op(7'h0d, 1'b1, 24'hffff5a, 22'h0);
    op(7'h0e, 1'b1, 24'hffc001, 22'h5a);
    op(7'h0d, 1'b0, 24'h0, 22'h0001);
    switchLevel[0] = 1'b1;
    switchLevel[9] = 1'b1;
    repeat (20) @(negedge clk);
    check(irqN, 1);
    switchLevel[1] = 1'b1;
    repeat (20) @(negedge clk);
    check(irqN, 0);
    op(7'h0e, 1'b0, 24'h0, 22'h5a);
    check({rep[30], irqN}, 32'h3);
    switchLevel[8] = 1'b1;
    repeat (20) @(negedge clk);
    check(irqN, 0);
    op(7'h0f, 1'b1, 24'h0, 22'h0001);
    nap();
    repeat (300) @(negedge clk);
    check(sleepState, 1);
    op(7'h0f, 1'b1, 24'h80, 22'h0);
    sleepRun();
    check({sleepState, irqN}, 32'h0);
    op(7'h0f, 1'b1, 24'h90, 22'h80);
    nap();
    sleepRun();
    check(n >= 70 && n <= 82, 1);
    check(seenPoll, 1);
    results();
  end
endmodule
`default_nettype wire
